// ---- rtl/dpc_pkg.sv ----
// Constants and types for the link port control block
// Behaviour
// - Disabled port tristates lanes; enabled drives the lanes in the lane count and tristates the rest
// - Swing code selects first-pattern differential swing
// - Pre-emphasis code selects second-pattern emphasis
// - Lane-count codes give one, two, four lanes
// - Lane count frozen while enabled, taken on re-enable
// - Lane swap reverses order, latched on re-enable
// - Auxiliary channel mapping unaffected by lane swap
// - Pattern 000b sends continuous D10.2
// - Pattern 001b full ten-symbol sequence completes unless the port is disabled
// - Scrambler and disparity reset after last sequence
// - Idle sends BS then VB-ID, repeated continuously
// - Pattern 011b sends normal pixel data
// - Enable bit write-blocked while sequencer owns panel
package dpc_pkg;
   localparam logic [31:0] CTL_RESET = 32'h0000_0018;
   localparam logic [31:0] CTL_WR_MASK = 32'h8FF8_8740;
   localparam logic [31:0] CTL_FIXED = 32'h0000_0018;
   localparam int EN_BIT = 31;
   localparam int SWING_LSB = 25;
   localparam int EMPH_LSB = 22;
   localparam int WIDTH_LSB = 19;
   localparam int REV_BIT = 15;
   localparam int PAT_LSB = 8;
   localparam int AUDIO_BIT = 6;
   localparam logic [2:0] WIDTH_X1 = 3'h0;
   localparam logic [2:0] WIDTH_X2 = 3'h1;
   localparam logic [2:0] WIDTH_X4 = 3'h3;
   localparam logic [1:0] LG_X1 = 2'h0;
   localparam logic [1:0] LG_X2 = 2'h1;
   localparam logic [1:0] LG_X4 = 2'h2;
   localparam logic [7:0] SYM_D10_2 = 8'h4A;
   localparam logic [7:0] SYM_D11_6 = 8'hCB;
   localparam logic [7:0] SYM_K28_5 = 8'hBC;
   localparam logic [7:0] SYM_BS = 8'hBC;
   localparam logic [7:0] SYM_VBID_NOVID = 8'h08;
   localparam logic [3:0] SEQ_LAST = 4'h9;
   localparam logic [3:0] TP2_K2 = 4'h2;
   localparam logic [3:0] TP2_D2 = 4'h3;
   typedef enum logic [2:0] {
      DPC_TP1 = 3'b000,
      DPC_TP2 = 3'b001,
      DPC_IDLE = 3'b010,
      DPC_NORM = 3'b011
   } dpc_pat_type;
endpackage

// ---- rtl/dpc_port_control.sv ----
// Link port control: register, enable timing, lane setup, pattern sequencer, pixel FIFO
`timescale 1ns/1ps
`default_nettype none

module dpc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LASTP = AW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [AW:0] cnt, next_cnt;
   logic next_in_ready;
   logic push, pop;

   always_comb begin
      push = in_valid && in_ready;
      pop = out_ready && out_valid;
      next_wp = push ? ((wp == LASTP) ? '0 : wp + 1'b1) : wp;
      next_rp = pop ? ((rp == LASTP) ? '0 : rp + 1'b1) : rp;
      next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
      // Ready is registered from the next count, so a full buffer refuses the very next word
      next_in_ready = next_cnt != FULL;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         in_ready <= 1'b0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
         in_ready <= next_in_ready;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   assign out_valid = cnt != '0;
   assign out_data = mem[rp];
endmodule

module dpc_port_control #(
   parameter int FIFO_DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Control register port
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Display timing and panel sequencer
   input wire logic vblank,
   input wire logic pps_owns_panel,
   // Pixel stream in
   input wire logic pix_valid,
   input wire logic [31:0] pix_data,
   output logic pix_ready,
   // Main link lanes: per lane {k flag, byte}
   output logic [35:0] lane_sym,
   output logic [3:0] lane_oe,
   output logic lane_power_down,
   output logic [2:0] vswing_code,
   output logic [2:0] preemph_code,
   output logic scramble_init,
   output logic audio_on
);
   logic [31:0] ctl, next_ctl;
   logic active, next_active;
   logic [1:0] lg, next_lg;
   logic rev, next_rev;
   dpc_pkg::dpc_pat_type pat, next_pat, req_pat;
   logic [3:0] idx, next_idx;
   logic [1:0] sub, next_sub, sub_max;
   logic next_scr;
   logic [35:0] next_sym;
   logic [3:0] next_oe;
   logic [2:0] nlanes;
   logic fifo_valid, fifo_pop;
   logic [31:0] fifo_data;

   dpc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .in_valid(pix_valid),
      .in_data(pix_data),
      .in_ready(pix_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_pop)
   );

   // Register, enable timing and lane lock
   always_comb begin
      next_ctl = ctl;
      if (reg_wr) begin
         next_ctl = (reg_wdata & dpc_pkg::CTL_WR_MASK) | dpc_pkg::CTL_FIXED;
         if (pps_owns_panel) begin
            next_ctl[dpc_pkg::EN_BIT] = ctl[dpc_pkg::EN_BIT];
         end
      end
      next_active = vblank ? ctl[dpc_pkg::EN_BIT] : active;
      next_lg = lg;
      next_rev = rev;
      if (next_active && !active) begin
         next_rev = ctl[dpc_pkg::REV_BIT];
         unique case (ctl[dpc_pkg::WIDTH_LSB +: 3])
            dpc_pkg::WIDTH_X2: next_lg = dpc_pkg::LG_X2;
            dpc_pkg::WIDTH_X4: next_lg = dpc_pkg::LG_X4;
            default: next_lg = dpc_pkg::LG_X1;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctl <= dpc_pkg::CTL_RESET;
         reg_rdata <= dpc_pkg::CTL_RESET;
         active <= 1'b0;
         lg <= dpc_pkg::LG_X1;
         rev <= 1'b0;
      end else begin
         ctl <= next_ctl;
         reg_rdata <= next_ctl;
         active <= next_active;
         lg <= next_lg;
         rev <= next_rev;
      end
   end

   // Pattern sequencer; reserved pattern codes keep the current pattern
   always_comb begin
      req_pat = dpc_pkg::dpc_pat_type'(ctl[dpc_pkg::PAT_LSB +: 3]);
      next_pat = pat;
      if (!active) begin
         next_pat = dpc_pkg::DPC_TP1;
      end else if (pat != dpc_pkg::DPC_TP2 || idx == dpc_pkg::SEQ_LAST) begin
         if (ctl[dpc_pkg::PAT_LSB + 2] == 1'b0) begin
            next_pat = req_pat;
         end
      end
      if (next_pat != pat || idx == dpc_pkg::SEQ_LAST) begin
         next_idx = '0;
      end else begin
         next_idx = idx + 1'b1;
      end
      next_scr = active && pat == dpc_pkg::DPC_TP2 && idx == dpc_pkg::SEQ_LAST
                 && next_pat != dpc_pkg::DPC_TP2;
   end

   // Pixel pacing: four bytes per word shared over the active lanes
   always_comb begin
      nlanes = 3'(1) << lg;
      sub_max = 2'(3'h3 >> lg);
      fifo_pop = active && pat == dpc_pkg::DPC_NORM && sub == sub_max;
      next_sub = sub;
      if (!active || pat != dpc_pkg::DPC_NORM) begin
         next_sub = '0;
      end else if (fifo_valid) begin
         next_sub = (sub == sub_max) ? 2'h0 : sub + 1'b1;
      end
   end

   // Lane enables follow the registered state, so they trail power-down by one cycle
   // Per physical lane symbol; the auxiliary channel never passes through here
   for (genvar p = 0; p < 4; p++) begin : g_lane
      logic [2:0] lg_lane;
      logic [1:0] bsel;
      logic [8:0] sym;
      always_comb begin
         lg_lane = rev ? (nlanes - 3'(1) - 3'(p)) : 3'(p);
         bsel = 2'((3'(sub) << lg) + lg_lane);
         sym = 9'h000;
         unique case (pat)
            dpc_pkg::DPC_TP1: sym = {1'b0, dpc_pkg::SYM_D10_2};
            dpc_pkg::DPC_TP2: begin
               if (idx == '0 || idx == dpc_pkg::TP2_K2) begin
                  sym = {1'b1, dpc_pkg::SYM_K28_5};
               end else if (idx == 4'h1 || idx == dpc_pkg::TP2_D2) begin
                  sym = {1'b0, dpc_pkg::SYM_D11_6};
               end else begin
                  sym = {1'b0, dpc_pkg::SYM_D10_2};
               end
            end
            dpc_pkg::DPC_IDLE: begin
               sym = idx[0] ? {1'b0, dpc_pkg::SYM_VBID_NOVID} : {1'b1, dpc_pkg::SYM_BS};
            end
            dpc_pkg::DPC_NORM: begin
               sym = fifo_valid ? {1'b0, fifo_data[8*bsel +: 8]} : 9'h000;
            end
            default: sym = 9'h000;
         endcase
         next_oe[p] = active && (3'(p) < nlanes);
         next_sym[9*p +: 9] = next_oe[p] ? sym : 9'h000;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pat <= dpc_pkg::DPC_TP1;
         idx <= '0;
         sub <= '0;
         scramble_init <= 1'b0;
         lane_sym <= '0;
         lane_oe <= '0;
         lane_power_down <= 1'b1;
         vswing_code <= '0;
         preemph_code <= '0;
         audio_on <= 1'b0;
      end else begin
         pat <= next_pat;
         idx <= next_idx;
         sub <= next_sub;
         scramble_init <= next_scr;
         lane_sym <= next_sym;
         lane_oe <= next_oe;
         lane_power_down <= !next_active;
         vswing_code <= next_ctl[dpc_pkg::SWING_LSB +: 3];
         preemph_code <= next_ctl[dpc_pkg::EMPH_LSB +: 3];
         audio_on <= next_active && next_ctl[dpc_pkg::AUDIO_BIT];
      end
   end

   property p_en_vblank;
      @(posedge clk_sys) disable iff (!rstn) active != $past(active) |-> $past(vblank);
   endproperty
   a_en_vblank: assert property (p_en_vblank) else $error("enable changed off vblank");

   property p_off_tristate;
      @(posedge clk_sys) disable iff (!rstn) !active |-> lane_power_down ##1 lane_oe == 4'h0;
   endproperty
   a_off_tristate: assert property (p_off_tristate) else $error("lanes driven while off");

   property p_x4_oe;
      @(posedge clk_sys) disable iff (!rstn) active && lg == dpc_pkg::LG_X4 |=> lane_oe == 4'hF;
   endproperty
   a_x4_oe: assert property (p_x4_oe) else $error("four lanes not all driven");

   property p_lock;
      @(posedge clk_sys) disable iff (!rstn) active && $past(active) |-> $stable(lg) && $stable(rev);
   endproperty
   a_lock: assert property (p_lock) else $error("lane setup moved while enabled");

   // Ten-symbol sequence: started at index 0, still the second pattern at index 9
   property p_tp2_done;
      @(posedge clk_sys) disable iff (!rstn)
         active && pat == dpc_pkg::DPC_TP2 && idx == 4'h0 ##1 active [*8] |=> pat == dpc_pkg::DPC_TP2;
   endproperty
   a_tp2_done: assert property (p_tp2_done) else $error("second pattern cut short");

   property p_scr;
      @(posedge clk_sys) disable iff (!rstn)
         scramble_init |-> $past(pat == dpc_pkg::DPC_TP2 && idx == dpc_pkg::SEQ_LAST);
   endproperty
   a_scr: assert property (p_scr) else $error("scrambler init at wrong point");

   property p_tp1_sym;
      @(posedge clk_sys) disable iff (!rstn)
         $past(active && pat == dpc_pkg::DPC_TP1) |-> lane_sym[8:0] == {1'b0, dpc_pkg::SYM_D10_2};
   endproperty
   a_tp1_sym: assert property (p_tp1_sym) else $error("first pattern symbol wrong");

   property p_block;
      @(posedge clk_sys) disable iff (!rstn)
         reg_wr && pps_owns_panel |=> ctl[dpc_pkg::EN_BIT] == $past(ctl[dpc_pkg::EN_BIT]);
   endproperty
   a_block: assert property (p_block) else $error("enable written while protected");

   property p_rsvd;
      @(posedge clk_sys) disable iff (!rstn)
         (reg_rdata & ~(dpc_pkg::CTL_WR_MASK | dpc_pkg::CTL_FIXED)) == 32'h0000_0000;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

   property p_audio;
      @(posedge clk_sys) disable iff (!rstn) audio_on |-> active && ctl[dpc_pkg::AUDIO_BIT];
   endproperty
   a_audio: assert property (p_audio) else $error("audio on without cause");
endmodule

`default_nettype wire

// ---- dv/dpc_sink.sv ----
// Display sink model: resolves each lane from its driver and shows what the sink receives
`timescale 1ns/1ps
`default_nettype none

module dpc_sink (
   // Main link from the port
   input wire logic [35:0] lane_sym,
   input wire logic [3:0] lane_oe,
   // Received lane levels, high impedance where the port does not drive
   output logic [35:0] rx_sym
);
   genvar g;
   for (g = 0; g < 4; g++) begin : g_lane
      assign rx_sym[9*g +: 9] = lane_oe[g] ? lane_sym[9*g +: 9] : 9'bz;
   end
endmodule

`default_nettype wire

// ---- dv/tb_dpc_port_control.sv ----
// Self-checking bench for the link port control block
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end

module tb_dpc_port_control;
   logic clk_sys, rstn, reg_wr, vblank, pps_owns_panel, pix_valid, pix_ready;
   logic lane_power_down, scramble_init, audio_on;
   logic [31:0] reg_wdata, reg_rdata, pix_data, w;
   logic [35:0] lane_sym, rx_sym;
   logic [3:0] lane_oe;
   logic [2:0] vswing_code, preemph_code;
   logic [8:0] prev;
   logic [31:0] q[$];
   int error_cnt, tests_run, i, k, n;

   dpc_port_control #(.FIFO_DEPTH(32)) dut (.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vblank(vblank), .pps_owns_panel(pps_owns_panel),
      .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready), .lane_sym(lane_sym),
      .lane_oe(lane_oe), .lane_power_down(lane_power_down), .vswing_code(vswing_code),
      .preemph_code(preemph_code), .scramble_init(scramble_init), .audio_on(audio_on));
   dpc_sink sink (.lane_sym(lane_sym), .lane_oe(lane_oe), .rx_sym(rx_sym));

   function automatic logic [31:0] exp_reg(input logic [31:0] v);
      return (v & dpc_pkg::CTL_WR_MASK) | dpc_pkg::CTL_FIXED;
   endfunction
   function automatic logic [8:0] exp_tp2(input int j);
      if (j < 4) begin
         return j[0] ? {1'b0, dpc_pkg::SYM_D11_6} : {1'b1, dpc_pkg::SYM_K28_5};
      end
      return {1'b0, dpc_pkg::SYM_D10_2};
   endfunction
   // Four reversed lanes: physical lane 3 carries byte 0
   function automatic logic [35:0] exp_rev(input logic [31:0] d);
      return {1'b0, d[7:0], 1'b0, d[15:8], 1'b0, d[23:16], 1'b0, d[31:24]};
   endfunction

   task automatic cyc(input int c);
      repeat (c) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [31:0] v);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_wdata = v;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic vb();
      @(negedge clk_sys);
      vblank = 1'b1;
      @(negedge clk_sys);
      vblank = 1'b0;
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic tmo(input int c, input int lim);
      if (c >= lim) begin
         error_cnt++;
         $display("CHECK FAILED wait expected %0d seen %0d", lim, c);
         close_out();
      end
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = '0;
      vblank = 1'b0;
      pps_owns_panel = 1'b0;
      pix_valid = 1'b0;
      pix_data = '0;
      error_cnt = 0;
      tests_run = 0;
      w = $urandom(98756);
      cyc(12);
      rstn = 1'b1;
      `CHK("reset value", dpc_pkg::CTL_RESET, reg_rdata)
      `CHK("reset power", 1'b1, lane_power_down)
      `CHK("reset lanes", {36{1'bz}}, rx_sym)
      // Random configuration while off, with reserved bits set
      for (i = 0; i < 8; i++) begin
         w = $urandom() & 32'h7FFF_FFFF;
         if (i == 0) w = 32'h7FFF_FFFF;
         wr(w);
         `CHK("register", exp_reg(w), reg_rdata)
         `CHK("swing", w[27:25], vswing_code)
         `CHK("emphasis", w[24:22], preemph_code)
         `CHK("audio off", 1'b0, audio_on)
      end
      pps_owns_panel = 1'b1;
      wr(32'h8008_0000);
      `CHK("enable blocked", 1'b0, reg_rdata[31])
      pps_owns_panel = 1'b0;
      wr(32'h8008_0000);
      cyc(3);
      `CHK("wait vblank", 4'h0, lane_oe)
      vb();
      `CHK("power up", 1'b0, lane_power_down)
      cyc(1);
      `CHK("two lanes", 4'h3, lane_oe)
      cyc(1);
      `CHK("pattern one", {{18{1'bz}}, 9'h04A, 9'h04A}, rx_sym)
      wr(32'h8018_0000);
      vb();
      `CHK("width locked", 4'h3, lane_oe)
      wr(32'h0018_8000);
      vb();
      `CHK("off power", 1'b1, lane_power_down)
      cyc(1);
      `CHK("off lanes", {36{1'bz}}, rx_sym)
      wr(32'h8018_8000);
      vb();
      cyc(1);
      `CHK("four lanes", 4'hF, lane_oe)
      wr(32'h8018_8100);
      prev = 9'h04A;
      for (k = 0; k < 30 && !(rx_sym[8:0] === 9'h1BC && prev === 9'h04A); k++) begin
         prev = rx_sym[8:0];
         cyc(1);
      end
      tmo(k, 30);
      for (i = 0; i < 10; i++) begin
         `CHK("pattern two", exp_tp2(i), rx_sym[8:0])
         `CHK("same lanes", exp_tp2(i), rx_sym[35:27])
         cyc(1);
      end
      wr(32'h8018_8200);
      for (k = 0; k < 20 && scramble_init !== 1'b1; k++) cyc(1);
      tmo(k, 20);
      cyc(1);
      `CHK("init pulse", 1'b0, scramble_init)
      for (k = 0; k < 20 && rx_sym[8:0] !== 9'h1BC; k++) cyc(1);
      tmo(k, 20);
      cyc(1);
      `CHK("idle vbid", 9'h008, rx_sym[8:0])
      // A reserved pattern code leaves the idle pattern running
      wr(32'h8018_8600);
      cyc(1);
      `CHK("reserved pattern", 1'b1, rx_sym[8:0] === 9'h1BC || rx_sym[8:0] === 9'h008)
      // Fill the buffer while the idle pattern holds it
      n = 0;
      repeat (40) begin
         @(negedge clk_sys);
         pix_valid = pix_ready;
         pix_data = $urandom();
         if (pix_ready === 1'b1) begin
            q.push_back(pix_data);
            n++;
         end
      end
      cyc(1);
      pix_valid = 1'b0;
      `CHK("buffer depth", 32, n)
      wr(32'h8018_8300);
      for (k = 0; k < 10 && rx_sym !== exp_rev(q[0]); k++) cyc(1);
      tmo(k, 10);
      foreach (q[j]) begin
         `CHK("pixels", exp_rev(q[j]), rx_sym)
         cyc(1);
      end
      cyc(2);
      `CHK("empty", 36'h0, rx_sym)
      wr(32'h8018_8340);
      cyc(2);
      `CHK("audio on", 1'b1, audio_on)
      wr(32'h0018_8340);
      vb();
      `CHK("audio gone", 1'b0, audio_on)
      cyc(1);
      `CHK("final off", {36{1'bz}}, rx_sym)
      wr(32'h8000_0000);
      vb();
      cyc(1);
      `CHK("one lane", 4'h1, lane_oe)
      close_out();
   end
endmodule

`default_nettype wire
